// File: dv/ase_engine_properties.sv
// assertions on the bus and sample ports of the sequence engine
`include "ase_defs.svh"
module ase_engine_chk import ase_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [11:0] sample_out,
  input wire logic        sample_valid_out,
  input wire logic        sync_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_rd_data;
    s_setup ##0 (!pwrite_in && paddr_in == `ASE_DATA);
  endsequence
  property p_ready;
    psel_in && penable_in |-> pready_out;
  endproperty
  property p_unaligned;
    s_setup ##0 (paddr_in[1:0] != 2'b00) |=> pslverr_out;
  endproperty
  property p_mapped;
    s_setup ##0 (paddr_in[1:0] == 2'b00 && paddr_in <= `ASE_DATA) |=> !pslverr_out;
  endproperty
  property p_wr_zero;
    s_setup ##0 pwrite_in |=> prdata_out == 32'h0000_0000;
  endproperty
  property p_data_rd;
    s_rd_data |=> prdata_out == 32'h0000_0000 && !pslverr_out;
  endproperty
  property p_hold;
    !(psel_in && !penable_in) |=> $stable(prdata_out) && $stable(pslverr_out);
  endproperty
  property p_smp_hold;
    $changed(sample_out) |-> sample_valid_out;
  endproperty
  property p_rst_out;
    $rose(rst_b_in) |-> !sample_valid_out && sync_out && sample_out == 12'h000;
  endproperty
  a_ready:     assert property (p_ready) else $error("access without ready");
  a_unaligned: assert property (p_unaligned) else $error("unaligned access not refused");
  a_mapped:    assert property (p_mapped) else $error("mapped access refused");
  a_wr_zero:   assert property (p_wr_zero) else $error("read data not zero on write");
  a_data_rd:   assert property (p_data_rd) else $error("data port read not zero");
  a_hold:      assert property (p_hold) else $error("bus answer moved outside setup");
  a_smp_hold:  assert property (p_smp_hold) else $error("sample moved without valid");
  a_rst_out:   assert property (p_rst_out) else $error("outputs not at reset values");
endmodule : ase_engine_chk

bind ase_engine ase_engine_chk u_ase_engine_chk (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .sample_out(sample_out), .sample_valid_out(sample_valid_out), .sync_out(sync_out)
);

// File: dv/ase_engine_tb_top.sv
// self-checking bench of the sequence engine
`include "ase_defs.svh"
module ase_engine_tb_top import ase_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 0;
  logic        rst_b_in = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, s_valid, sync;
  logic [11:0] smp;
  int          error_cnt = 0, total_checks = 0, base = 0;
  logic        trig_e = 0, trig_m = 0, trig_l = 0;
  int          ex [0:63], cur [0:63];
  logic        mk [0:63];
  always #2 mclk_in = ~mclk_in;
  ase_engine u_ase_engine (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .trig_edge_in(trig_e), .manual_trigger_key_in(trig_m), .trig_level_in(trig_l),
    .sample_out(smp), .sample_valid_out(s_valid), .sync_out(sync));
  ase_sample_sink u_ase_sample_sink (.mclk_in(mclk_in), .sample_valid_in(s_valid),
    .sample_in(smp), .sync_in(sync));
  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_in);
    penable <= 1;
    do
    begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic cmd(input logic [31:0] c);
    int n;
    n = 0;
    apb(1, `ASE_CMD, c);
    do
    begin
      apb(0, `ASE_STAT, 0);
      n++;
    end while (rd[11] !== 1'b0 && n < 1000);
    if (n >= 1000)
    begin
      error_cnt++;
      give_verdict();
    end
  endtask : cmd
  task automatic range(input int s, input int e);
    apb(1, `ASE_START, 32'(s));
    apb(1, `ASE_STOP, 32'(e));
  endtask : range
  function automatic int clip(input int v);
    return v > 2047 ? 2047 : (v < -2048 ? -2048 : v);
  endfunction : clip
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge mclk_in);
    rst_b_in <= 1;
    apb(0, `ASE_FACTOR, 0); chk(rd, 32'h0000_0064);
    apb(0, `ASE_BURST, 0); chk(rd, 32'h0000_0001);
    apb(0, 12'h038, 0); chk({31'h0, err}, 1);
    apb(0, 12'h002, 0); chk({31'h0, err}, 1);
    apb(1, `ASE_SEGEN, 32'h0000_0000); apb(0, `ASE_SEGEN, 0); chk(rd, 1);
    apb(1, `ASE_SEGEN, 32'h0000_0013); apb(0, `ASE_SEGEN, 0); chk(rd, 4);
    apb(1, `ASE_SEGEN, 32'h0000_0001); apb(0, `ASE_SEGEN, 0); chk(rd, 1);
    apb(1, `ASE_MADDR, 0);
    for (int i = 0; i < 64; i++)
    begin
      ex[i] = i * 50 - 1600;
      cur[i] = ex[i];
      mk[i] = (i >= 40 && i <= 57) ? ((i - 40) % 16 < 8) : 1'b0;
      apb(1, `ASE_DATA, 32'(ex[i]));
    end
    range(0, 3); apb(1, `ASE_FACTOR, 200); cmd(0);
    for (int i = 0; i < 4; i++) cur[i] = clip(ex[i] * 200 / 100);
    range(0, 1); cmd(3);
    cur[0] = ex[0];
    cur[1] = ex[1];
    cmd(4);
    range(2, 3); cmd(3);
    range(60, 63); apb(1, `ASE_OFFSET, 32'h0000_0FFF); cmd(1);
    for (int i = 60; i < 64; i++) cur[i] = clip(cur[i] + 4095);
    apb(0, `ASE_STAT, 0); chk({31'h0, rd[12]}, 1);
    range(10, 11); cmd(2); cmd(2);
    range(20, 20); cmd(2);
    cur[20] = -cur[20];
    apb(1, `ASE_MADDR, 5); cmd(5);
    apb(1, `ASE_MADDR, 6); cmd(5); cmd(5);
    mk[5] = 1'b1;
    range(40, 57); apb(1, `ASE_PAT, 32'h0101_0001); cmd(6);
    cmd(7);
    apb(1, 12'h040, 0); apb(1, `ASE_CTRL, 32'h0000_0004); apb(1, `ASE_SEQ, 1);
    for (int n = 0; n < 2000 && u_ase_sample_sink.cnt < 65; n++) @(posedge mclk_in);
    for (int i = 0; i < 65; i++)
    begin
      chk({20'h0, u_ase_sample_sink.smp[i]}, {20'h0, 12'(cur[i % 64])});
      chk({31'h0, u_ase_sample_sink.syn[i]}, {31'h0, mk[i % 64]});
    end
    // sequence sync: segment of two cycles, low through its second cycle
    apb(1, `ASE_SEQ, 0);
    repeat (4) @(posedge mclk_in);
    base = u_ase_sample_sink.cnt;
    apb(1, 12'h040, 32'h0000_0001); apb(1, `ASE_CTRL, 0); apb(1, `ASE_SEQ, 1);
    for (int n = 0; n < 2000 && u_ase_sample_sink.cnt < base + 128; n++) @(posedge mclk_in);
    for (int i = 0; i < 128; i++)
    begin
      chk({20'h0, u_ase_sample_sink.smp[(base + i) % 256]}, {20'h0, 12'(cur[i % 64])});
      chk({31'h0, u_ase_sample_sink.syn[(base + i) % 256]}, (i < 64) ? 1 : 0);
    end
    // edge with burst, then level with manual key: each start is refused and sets the error bit
    apb(1, `ASE_SEQ, 0); apb(1, 12'h040, 32'h0000_8000); apb(1, `ASE_CTRL, 32'h0000_000C);
    apb(1, `ASE_SEQ, 1); apb(0, `ASE_STAT, 0); chk({31'h0, rd[13]}, 1);
    apb(1, `ASE_SEQ, 0); apb(1, 12'h040, 32'h0001_0000); apb(1, `ASE_CTRL, 32'h0000_0024);
    apb(1, `ASE_SEQ, 1); apb(0, `ASE_STAT, 0); chk({31'h0, rd[13]}, 1);
    give_verdict();
  end
endmodule : ase_engine_tb_top

// File: dv/ase_sample_sink.sv
// sample output path model: records every played sample with its sync level
module ase_sample_sink
(
  input wire logic        mclk_in,
  input wire logic        sample_valid_in,
  input wire logic [11:0] sample_in,
  input wire logic        sync_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] smp [0:255];
  logic        syn [0:255];
  int          cnt = 0;
  always @(posedge mclk_in)
  begin
    if (sample_valid_in === 1'b1)
    begin
      smp[cnt % 256] <= sample_in;
      syn[cnt % 256] <= sync_in;
      cnt            <= cnt + 1;
    end
  end
endmodule : ase_sample_sink

// File: src/ase_defs.svh
// constants of the arbitrary sequence engine: widths, offsets, fields, resets
`ifndef ASE_DEFS_SVH
`define ASE_DEFS_SVH
// ----------------------------------------------------------------
// widths and sizes
// ----------------------------------------------------------------
`define ASE_AW      10
`define ASE_DW      13
`define ASE_MRK     12
`define ASE_NCH     2
`define ASE_NSEG    16
`define ASE_PMAX    6'h3F
`define ASE_ALAST   10'h3FF
`define ASE_SMAX    28'sh000_07FF
`define ASE_SMIN    28'shFFF_F800
`define ASE_FDIV    28'sh000_0064
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ASE_CTRL    12'h000
`define ASE_CMD     12'h004
`define ASE_START   12'h008
`define ASE_STOP    12'h00C
`define ASE_FACTOR  12'h010
`define ASE_OFFSET  12'h014
`define ASE_PAT     12'h018
`define ASE_MADDR   12'h01C
`define ASE_STAT    12'h020
`define ASE_BURST   12'h024
`define ASE_SEGEN   12'h028
`define ASE_WID     12'h02C
`define ASE_SEQ     12'h030
`define ASE_DATA    12'h034
`define ASE_SEGPG   6'h01
// ----------------------------------------------------------------
// control bits, command bits and reset values
// ----------------------------------------------------------------
`define ASE_C_ECH   0
`define ASE_C_PCH   1
`define ASE_C_SYNC  2
`define ASE_C_BRST  3
`define ASE_C_GATE  4
`define ASE_C_LMAN  5
`define ASE_K_CONF  3
`define ASE_FAC_RST 14'h0064
`define ASE_BUR_RST 20'h0_0001
`define ASE_SEG_RST 21'h00_0000
`endif

// File: src/ase_engine.sv
// waveform section editor and segment sequencer with an apb register file
//
// Decided for this implementation: the APB register port and the placing of the registers.
`include "ase_defs.svh"
module ase_engine import ase_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        trig_edge_in,
  input  wire logic        manual_trigger_key_in,
  input  wire logic        trig_level_in,
  output logic      [11:0] sample_out,
  output logic             sample_valid_out,
  output logic             sync_out
);
  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && ((a <= `ASE_DATA) || (a[11:6] == `ASE_SEGPG));
  endfunction : mapped

  function automatic logic signed [11:0] sat(input logic signed [27:0] v);
    if (v > `ASE_SMAX)
      sat = 12'(`ASE_SMAX);
    else if (v < `ASE_SMIN)
      sat = 12'(`ASE_SMIN);
    else
      sat = 12'(v);
  endfunction : sat

  function automatic logic [15:0] fill(input logic [15:0] p, input logic [15:0] m);
    logic v;
    v = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      if (m[i])
        v = p[i];
      fill[i] = v;
    end
  endfunction : fill

  // ----------------------------------------------------------------
  // apb slave and configuration registers
  // ----------------------------------------------------------------
  logic [5:0]          ctrl;
  logic [9:0]          start_a;
  logic [9:0]          stop_a;
  logic [9:0]          mark_a;
  logic [13:0]         factor;
  logic [12:0]         offs;
  logic [31:0]         pat;
  logic [19:0]         burst_n;
  logic [4:0]          seg_cnt;
  logic [7:0]          wave_id;
  logic [20:0]         seg_cfg [`ASE_NSEG];
  logic                wr;
  logic                ld_we;
  logic                cmd_go;
  ase_op_t             cmd_op;
  ase_edit_st_t        e_st;
  ase_seq_st_t         s_st;
  logic [3:0]          seg;
  logic                clip;
  logic                seq_err;
  logic [31:0]         rd_mux;

  assign pready_out = 1'b1;
  assign wr         = psel_in & penable_in & pwrite_in & mapped(paddr_in);
  assign ld_we      = wr && (paddr_in == `ASE_DATA) && (e_st == E_IDLE);
  assign cmd_op     = ase_op_t'(pwdata_in[2:0]);
  // a clear-all without its confirm bit is a cancel and starts nothing
  assign cmd_go     = wr && (paddr_in == `ASE_CMD) && (e_st == E_IDLE)
                      && !(cmd_op == OP_CLEAR && !pwdata_in[`ASE_K_CONF]);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      `ASE_CTRL:   rd_mux = {26'h0, ctrl};
      `ASE_START:  rd_mux = {22'h0, start_a};
      `ASE_STOP:   rd_mux = {22'h0, stop_a};
      `ASE_FACTOR: rd_mux = {18'h0, factor};
      `ASE_OFFSET: rd_mux = {19'h0, offs};
      `ASE_PAT:    rd_mux = pat;
      `ASE_MADDR:  rd_mux = {22'h0, mark_a};
      `ASE_STAT:   rd_mux = {18'h0, seq_err, clip, e_st != E_IDLE, s_st, seg, seg_cnt};
      `ASE_BURST:  rd_mux = {12'h0, burst_n};
      `ASE_SEGEN:  rd_mux = {27'h0, seg_cnt};
      `ASE_WID:    rd_mux = {24'h0, wave_id};
      default:
      begin
        if (paddr_in[11:6] == `ASE_SEGPG)
          rd_mux = {11'h0, seg_cfg[paddr_in[5:2]]};
      end
    endcase
  end

  // read data and error are set up in the setup phase, so zero wait states
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end
    else if (psel_in && !penable_in)
    begin
      prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
      pslverr_out <= !mapped(paddr_in);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      ctrl    <= '0;
      start_a <= '0;
      stop_a  <= '0;
      factor  <= `ASE_FAC_RST;
      offs    <= '0;
      pat     <= '0;
      burst_n <= `ASE_BUR_RST;
      wave_id <= '0;
      for (int i = 0; i < `ASE_NSEG; i++)
        seg_cfg[i] <= `ASE_SEG_RST;
    end
    else if (wr)
    begin
      case (paddr_in)
        `ASE_CTRL:   ctrl    <= pwdata_in[5:0];
        `ASE_START:  start_a <= pwdata_in[9:0];
        `ASE_STOP:   stop_a  <= pwdata_in[9:0];
        `ASE_FACTOR: factor  <= pwdata_in[13:0];
        `ASE_OFFSET: offs    <= pwdata_in[12:0];
        `ASE_PAT:    pat     <= pwdata_in;
        `ASE_BURST:  burst_n <= pwdata_in[19:0];
        `ASE_WID:    wave_id <= pwdata_in[7:0];
        default:
        begin
          if (paddr_in[11:6] == `ASE_SEGPG)
            seg_cfg[paddr_in[5:2]] <= pwdata_in[20:0];
        end
      endcase
    end
  end

  // segment enables stay contiguous from segment 0
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      seg_cnt <= 5'h01;
    else if (wr && paddr_in == `ASE_SEGEN)
    begin
      if (pwdata_in[4] && ({1'b0, pwdata_in[3:0]} >= seg_cnt))
        seg_cnt <= 5'({1'b0, pwdata_in[3:0]} + 5'h01);
      else if (!pwdata_in[4] && pwdata_in[3:0] != 4'h0 && {1'b0, pwdata_in[3:0]} < seg_cnt)
        seg_cnt <= {1'b0, pwdata_in[3:0]};
    end
  end

  // ----------------------------------------------------------------
  // memories: backup plus one per channel
  // ----------------------------------------------------------------
  logic [9:0]          e_addr;
  logic [9:0]          e_end;
  logic [3:0]          e_pos;
  ase_op_t             e_op;
  logic [12:0]         new_w;
  logic [12:0]         src_w;
  logic [12:0]         bk_ra;
  logic [12:0]         ch_ra [`ASE_NCH];
  logic [12:0]         ch_rb [`ASE_NCH];
  logic [9:0]          p_addr;
  logic [9:0]          w_addr;
  logic [12:0]         w_data;
  logic                e_wr;
  logic                ech;

  assign ech    = ctrl[`ASE_C_ECH];
  assign e_wr   = (e_st == E_WR);
  assign w_addr = ld_we ? mark_a : e_addr;
  assign w_data = ld_we ? {1'b0, pwdata_in[11:0]} : new_w;

  ase_wave_mem u_backup (
    .mclk_in     (mclk_in),
    .rst_b_in    (rst_b_in),
    .we_in       (ld_we || (e_wr && e_op == OP_SAVE)),
    .waddr_in    (w_addr),
    .wdata_in    (w_data),
    .ra_addr_in  (e_addr),
    .rb_addr_in  (p_addr),
    .ra_data_out (bk_ra),
    .rb_data_out ()
  );

  for (genvar c = 0; c < `ASE_NCH; c++)
  begin : g_ch
    logic sel;
    logic same;
    assign sel  = (ech == 1'(c));
    assign same = (wave_id[4*c +: 4] == wave_id[4*ech +: 4]);
    ase_wave_mem u_chan (
      .mclk_in     (mclk_in),
      .rst_b_in    (rst_b_in),
      // edits land on the selected channel, a save on the other copies
      .we_in       ((ld_we && sel) || (e_wr && ((e_op != OP_SAVE) ? sel
                                               : (!sel && same)))),
      .waddr_in    (w_addr),
      .wdata_in    (w_data),
      .ra_addr_in  (e_addr),
      .rb_addr_in  (p_addr),
      .ra_data_out (ch_ra[c]),
      .rb_data_out (ch_rb[c])
    );
  end

  // ----------------------------------------------------------------
  // section editor: two cycles per address, read then write back
  // ----------------------------------------------------------------
  logic signed [27:0] s_ext;
  logic signed [27:0] prod;
  logic signed [27:0] sum;
  logic [15:0]        pfill;

  assign src_w = (e_op == OP_UNDO) ? bk_ra : ch_ra[ech];
  assign s_ext = {{16{src_w[11]}}, src_w[11:0]};
  assign prod  = (s_ext * $signed({14'h0000, factor})) / `ASE_FDIV;
  assign sum   = s_ext + {{15{offs[12]}}, offs};
  assign pfill = fill(pat[15:0], pat[31:16]);

  always_comb
  begin
    new_w = src_w;
    case (e_op)
      OP_SCALE:   new_w = {src_w[`ASE_MRK], sat(prod)};
      OP_OFFSET:  new_w = {src_w[`ASE_MRK], sat(sum)};
      OP_INVERT:  new_w = {src_w[`ASE_MRK], sat(-s_ext)};
      OP_TOGGLE:  new_w = {~src_w[`ASE_MRK], src_w[11:0]};
      OP_PATTERN: new_w = {pfill[e_pos], src_w[11:0]};
      OP_CLEAR:   new_w = {1'b0, src_w[11:0]};
      default:    new_w = src_w;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      e_st   <= E_IDLE;
      e_op   <= OP_SCALE;
      e_addr <= '0;
      e_end  <= '0;
      e_pos  <= '0;
    end
    else
    begin
      case (e_st)
        E_IDLE:
        begin
          if (cmd_go)
          begin
            e_st   <= E_RD;
            e_op   <= cmd_op;
            e_pos  <= '0;
            // a save covers the whole memory so no original survives it
            e_addr <= (cmd_op == OP_TOGGLE) ? mark_a
                      : (cmd_op == OP_CLEAR || cmd_op == OP_SAVE) ? '0 : start_a;
            e_end  <= (cmd_op == OP_TOGGLE) ? mark_a
                      : (cmd_op == OP_CLEAR || cmd_op == OP_SAVE) ? `ASE_ALAST
                      : stop_a;
          end
        end
        E_RD:
          e_st <= E_WR;
        E_WR:
        begin
          e_addr <= 10'(e_addr + 10'h001);
          e_pos  <= 4'(e_pos + 4'h1);
          e_st   <= (e_addr == e_end) ? E_IDLE : E_RD;
        end
        default:
          e_st <= E_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      clip <= 1'b0;
    else if (e_wr && e_op == OP_OFFSET && (sum > `ASE_SMAX || sum < `ASE_SMIN))
      clip <= 1'b1;
    else if (cmd_go)
      clip <= 1'b0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      mark_a <= '0;
    else if (wr && paddr_in == `ASE_MADDR)
      mark_a <= pwdata_in[9:0];
    else if (ld_we)
      mark_a <= 10'(mark_a + 10'h001);
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [5:0]   pos;
  logic [14:0]  loop_n;
  logic [1:0]   pend;
  logic [19:0]  passes;
  logic [20:0]  cur;
  ase_step_t    step;
  logic         trig;
  logic         hold;
  logic         last;
  logic         fin;
  logic         eoc;
  logic         any_edge;
  logic         any_lvl;
  logic         ok;
  logic         go_req;
  logic         stop_req;

  assign cur      = seg_cfg[seg];
  assign step     = ase_step_t'(cur[16:15]);
  assign p_addr   = {cur[20:17], pos};
  assign trig     = trig_edge_in | manual_trigger_key_in;
  assign hold     = ctrl[`ASE_C_GATE] && !trig_level_in;
  assign last     = ({1'b0, seg} == 5'(seg_cnt - 5'h01));
  assign eoc      = (pos == `ASE_PMAX);
  assign go_req   = wr && paddr_in == `ASE_SEQ && pwdata_in[0];
  assign stop_req = wr && paddr_in == `ASE_SEQ && !pwdata_in[0];

  always_comb
  begin
    any_edge = 1'b0;
    any_lvl  = 1'b0;
    for (int i = 0; i < `ASE_NSEG; i++)
    begin
      if (5'(i) < seg_cnt)
      begin
        any_edge = any_edge | (seg_cfg[i][16:15] == STEP_EDGE);
        any_lvl  = any_lvl | (seg_cfg[i][16:15] == STEP_LEVEL);
      end
    end
  end

  // burst and gate need all-count segments; level stepping refuses the manual key
  assign ok = !((ctrl[`ASE_C_BRST] || ctrl[`ASE_C_GATE]) && (any_edge || any_lvl))
              && !(ctrl[`ASE_C_LMAN] && any_lvl);

  // true while the current cycle is the segment's final one
  always_comb
  begin
    case (step)
      STEP_COUNT: fin = (loop_n == cur[14:0]);
      STEP_EDGE:  fin = (pend == 2'h1);
      STEP_LEVEL: fin = trig_level_in;
      default:    fin = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      s_st    <= S_IDLE;
      seg     <= '0;
      pos     <= '0;
      loop_n  <= '0;
      pend    <= '0;
      passes  <= '0;
      seq_err <= 1'b0;
    end
    else if (stop_req)
      s_st <= S_IDLE;
    else if ((s_st == S_IDLE && go_req) || (s_st == S_ARM && trig))
    begin
      seq_err <= !ok;
      if (ok)
        s_st <= (ctrl[`ASE_C_BRST] && s_st == S_IDLE) ? S_ARM : S_PLAY;
      seg    <= '0;
      pos    <= '0;
      loop_n <= '0;
      pend   <= '0;
      passes <= '0;
    end
    else if (s_st == S_PLAY && !hold)
    begin
      pos <= 6'(pos + 6'h01);
      if (!eoc && trig && step == STEP_EDGE && pend == 2'h0)
        pend <= 2'h2;
      if (eoc && fin)
      begin
        loop_n <= '0;
        pend   <= '0;
        seg    <= last ? 4'h0 : 4'(seg + 4'h1);
        if (last && ctrl[`ASE_C_BRST])
        begin
          passes <= 20'(passes + 20'h0_0001);
          if (20'(passes + 20'h0_0001) >= burst_n)
            s_st <= S_ARM;
        end
      end
      else if (eoc)
      begin
        loop_n <= 15'(loop_n + 15'h0001);
        if (pend == 2'h2 || (trig && step == STEP_EDGE && pend == 2'h0))
          pend <= 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample and sync outputs, aligned with the registered memory read
  // ----------------------------------------------------------------
  logic v1;
  logic ss1;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      v1               <= 1'b0;
      ss1              <= 1'b0;
      sample_out       <= '0;
      sample_valid_out <= 1'b0;
      sync_out         <= 1'b1;
    end
    else
    begin
      v1               <= (s_st == S_PLAY) && !hold;
      ss1              <= (s_st == S_PLAY) && last && fin;
      sample_valid_out <= v1;
      if (v1)
        sample_out <= ch_rb[ctrl[`ASE_C_PCH]][11:0];
      if (ctrl[`ASE_C_SYNC])
        sync_out <= v1 && ch_rb[ctrl[`ASE_C_PCH]][`ASE_MRK];
      else
        sync_out <= !(v1 && ss1);
    end
  end
endmodule : ase_engine

// File: src/ase_pkg.sv
// types of the arbitrary sequence engine
package ase_pkg;
  typedef enum logic [1:0] {E_IDLE = 2'b00, E_RD = 2'b01, E_WR = 2'b11} ase_edit_st_t;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_ARM = 2'b01, S_PLAY = 2'b11} ase_seq_st_t;
  typedef enum logic [2:0] {
    OP_SCALE, OP_OFFSET, OP_INVERT, OP_UNDO, OP_SAVE, OP_TOGGLE, OP_PATTERN, OP_CLEAR
  } ase_op_t;
  typedef enum logic [1:0] {STEP_COUNT, STEP_EDGE, STEP_LEVEL, STEP_RSVD} ase_step_t;
endpackage : ase_pkg

// File: src/ase_wave_mem.sv
// sample and marker memory with one write port and two registered read ports
`include "ase_defs.svh"
module ase_wave_mem import ase_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                rst_b_in,
  input  wire logic                we_in,
  input  wire logic [`ASE_AW-1:0]  waddr_in,
  input  wire logic [`ASE_DW-1:0]  wdata_in,
  input  wire logic [`ASE_AW-1:0]  ra_addr_in,
  input  wire logic [`ASE_AW-1:0]  rb_addr_in,
  output logic      [`ASE_DW-1:0]  ra_data_out,
  output logic      [`ASE_DW-1:0]  rb_data_out
);
  logic [`ASE_DW-1:0] mem [1 << `ASE_AW];

  always_ff @(posedge mclk_in)
  begin
    if (we_in)
      mem[waddr_in] <= wdata_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      ra_data_out <= '0;
      rb_data_out <= '0;
    end
    else
    begin
      ra_data_out <= mem[ra_addr_in];
      rb_data_out <= mem[rb_addr_in];
    end
  end
endmodule : ase_wave_mem
